/* File: hdl/bus_area_config_read_waits.sv */
// module: bus area function and read wait registers with the bus cycle timing they steer
`timescale 1ns/1ps

// Overview of operation
// - function register 16 bits, power-on zero, kept
// - bit 15 makes area 1 DRAM
// - bit 14 makes area 6 muxed I/O
// - bit 13 lets external overlap internal access
// - bit 12 picks 50% or 35% strobe high
// - bit 11 picks byte strobe signal style
// - function bits 10..0 read zero
// - wait register 16 bits, power-on ones, kept
// - wait bits 15..8 enable wait per area
// - areas 1,3,4,5,7: one or two+wait states
// - areas 0,2,6: one plus long waits, +wait
// - DRAM read column cycle short or long pitch
// - refresh adds refresh waits only with wait bit 9 set, ignores wait
// - muxed I/O read: four states plus wait
// - muxed I/O always samples wait
// - peripheral reads: three states, no wait
// - on-chip ROM/RAM reads: one state, no wait
// - wait register bits 7..2, 0 read one
// - bit 1 picks DRAM write pitch
module bus_area_config_read_waits
    import bus_area_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     manual_rst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     cyc_valid,
    input  wire bus_area_pkg::cycle_req_t cyc_req,
    input  wire logic [1:0]               hi_byte_en,
    output logic                          cyc_ready,
    output logic                          cyc_done,
    output logic                          cyc_busy,
    input  wire logic [1:0]               long_wait_area02,
    input  wire logic [1:0]               long_wait_area6,
    input  wire logic [1:0]               refresh_wait_count,
    input  wire logic                     wait_n,
    output logic                          internal_access_hold,
    output logic                          area1_dram_enable,
    output logic                          area6_muxed_io_enable,
    output logic                          parallel_access_mode,
    output logic                          read_strobe_duty_select,
    output logic                          upper_byte_store_strobe_n,
    output logic                          lower_byte_store_strobe_n,
    output logic                          low_byte_select_n,
    output logic                          high_byte_select_n,
    output logic                          shared_store_strobe_n
);
    import bus_area_pkg::*;

    logic [15:0] bus_area_function_control;
    logic [15:0] read_wait_state_control;
    logic        setup_phase;
    logic        write_take;
    logic        addr_hit;
    logic        start;
    logic        final_state;
    cycle_plan_t plan;
    logic        cur_write;
    logic [1:0]  cur_lanes;
    logic        plan_sampled;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // read data is captured in the setup phase so the access phase can
    // complete at once with registered data
    assign addr_hit    = (paddr == BUS_AREA_FUNCTION_CONTROL_ADDR)
                      || (paddr == READ_WAIT_STATE_CONTROL_ADDR);
    assign setup_phase = psel && !penable;
    assign write_take  = psel && penable && pwrite && addr_hit;
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !addr_hit;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (setup_phase)
        begin
            case (paddr)
                BUS_AREA_FUNCTION_CONTROL_ADDR: prdata <= {16'h0000, bus_area_function_control};
                READ_WAIT_STATE_CONTROL_ADDR:   prdata <= {16'h0000, read_wait_state_control};
                default:                        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // only the power-on reset loads these (function to zero, wait to ones); manual reset leaves them alone
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_area_function_control <= BUS_AREA_FUNCTION_CONTROL_RESET;
        else if (write_take && paddr == BUS_AREA_FUNCTION_CONTROL_ADDR)
            bus_area_function_control <= pwdata[15:0] & BUS_AREA_WRITABLE_MASK;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            read_wait_state_control <= READ_WAIT_STATE_CONTROL_RESET;
        else if (write_take && paddr == READ_WAIT_STATE_CONTROL_ADDR)
            read_wait_state_control <= (pwdata[15:0] & READ_WAIT_WRITABLE_MASK)
                                     | READ_WAIT_FIXED_ONES;
    end

    assign area1_dram_enable       = bus_area_function_control[AREA1_DRAM_ENABLE_BIT];
    assign area6_muxed_io_enable   = bus_area_function_control[AREA6_MUXED_IO_ENABLE_BIT];
    assign parallel_access_mode    = bus_area_function_control[PARALLEL_ACCESS_MODE_BIT];
    // the sub-state strobe edge is placed by the pad timing generator
    assign read_strobe_duty_select = bus_area_function_control[READ_STROBE_DUTY_SELECT_BIT];

    // ------------------------------------------------------------
    // cycle planning
    // ------------------------------------------------------------
    function automatic cycle_plan_t plan_cycle(
        input cycle_req_t  req,
        input logic [15:0] fn_ctl,
        input logic [15:0] wait_ctl,
        input logic [1:0]  lw02,
        input logic [1:0]  lw6,
        input logic [1:0]  rfw
    );
        cycle_plan_t p;
        logic        rw;
        p  = '{base_states: STATES_SHORT, fixed_waits: 2'h0, sample_wait: 1'b0};
        rw = wait_ctl[READ_WAIT_SAMPLE_LSB + int'(req.area)];
        if (req.internal)
        begin
            if (req.area == AREA_PERIPH)
                p.base_states = STATES_PERIPH;
            else
                p.base_states = STATES_SHORT;
        end
        else if (req.area == AREA_DRAM_OR_EXT && fn_ctl[AREA1_DRAM_ENABLE_BIT])
        begin
            if (req.refresh)
            begin
                p.base_states = wait_ctl[READ_WAIT_SAMPLE_LSB + 1] ? STATES_LONG : STATES_SHORT;
                p.fixed_waits = wait_ctl[READ_WAIT_SAMPLE_LSB + 1] ? rfw : 2'h0;
            end
            else if (req.write)
            begin
                p.base_states = wait_ctl[DRAM_WRITE_PITCH_SELECT_BIT] ? STATES_LONG
                                                                       : STATES_SHORT;
                p.sample_wait = wait_ctl[DRAM_WRITE_PITCH_SELECT_BIT];
            end
            else
            begin
                p.base_states = rw ? STATES_LONG : STATES_SHORT;
                p.sample_wait = rw;
            end
        end
        else if (req.area == AREA_MUXED_IO && fn_ctl[AREA6_MUXED_IO_ENABLE_BIT])
        begin
            p.base_states = STATES_MUXED;
            p.sample_wait = 1'b1;
        end
        else if (req.area == AREA_DRAM_OR_EXT && req.write)
        begin
            // pitch bit must stay set here, so this is always the long form
            p.base_states = STATES_LONG;
            p.sample_wait = 1'b1;
        end
        else if (req.area == AREA_ROM_OR_EXT0 || req.area == AREA_EXT2
                 || req.area == AREA_MUXED_IO)
        begin
            p.base_states = STATES_SHORT;
            p.fixed_waits = (req.area == AREA_MUXED_IO) ? lw6 : lw02;
            p.sample_wait = rw;
        end
        else
        begin
            p.base_states = rw ? STATES_LONG : STATES_SHORT;
            p.sample_wait = rw;
        end
        return p;
    endfunction

    assign plan      = plan_cycle(cyc_req, bus_area_function_control, read_wait_state_control,
                                  long_wait_area02, long_wait_area6, refresh_wait_count);
    assign start     = cyc_valid && cyc_ready;
    assign cyc_ready = !cyc_busy && !cyc_done && manual_rst_n;

    cycle_state_timer u_timer (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .start       (start),
        .plan        (plan),
        .wait_n      (wait_n),
        .busy        (cyc_busy),
        .final_state (final_state),
        .done        (cyc_done)
    );

    // internal masters stall behind an external cycle unless overlap is on
    assign internal_access_hold = cyc_busy && !cyc_req.internal && !parallel_access_mode;

    // ------------------------------------------------------------
    // byte strobes for word-space writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cur_write <= 1'b0;
            cur_lanes <= 2'h0;
        end
        else if (start)
        begin
            cur_write <= cyc_req.write && !cyc_req.internal;
            cur_lanes <= hi_byte_en;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upper_byte_store_strobe_n <= 1'b1;
            lower_byte_store_strobe_n <= 1'b1;
            low_byte_select_n         <= 1'b1;
            high_byte_select_n        <= 1'b1;
            shared_store_strobe_n     <= 1'b1;
        end
        else
        begin
            // style 0 pairs per-lane write strobes with address bit 0 from the address path
            upper_byte_store_strobe_n <= !(start && cyc_req.write && !cyc_req.internal
                                           && !bus_area_function_control[BYTE_STROBE_STYLE_SELECT_BIT]
                                           && hi_byte_en[1]) && !(cyc_busy && !cyc_done
                                           && cur_write && !final_state
                                           && !bus_area_function_control[BYTE_STROBE_STYLE_SELECT_BIT]
                                           && cur_lanes[1]);
            lower_byte_store_strobe_n <= !(cyc_busy && cur_write
                                           && !bus_area_function_control[BYTE_STROBE_STYLE_SELECT_BIT]
                                           && cur_lanes[0]);
            low_byte_select_n         <= !(cyc_busy && cur_write && cur_lanes[0]
                                           && bus_area_function_control[BYTE_STROBE_STYLE_SELECT_BIT]);
            high_byte_select_n        <= !(cyc_busy && cur_write && cur_lanes[1]
                                           && bus_area_function_control[BYTE_STROBE_STYLE_SELECT_BIT]);
            shared_store_strobe_n     <= !(cyc_busy && cur_write
                                           && bus_area_function_control[BYTE_STROBE_STYLE_SELECT_BIT]);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_rom_start;
        start && cyc_req.internal && cyc_req.area == AREA_ROM_OR_EXT0;
    endsequence

    sequence s_periph_start;
        start && cyc_req.internal && cyc_req.area == AREA_PERIPH;
    endsequence

    property p_function_reserved_zero;
        @(posedge core_clk) disable iff (!rst_n)
        bus_area_function_control[10:0] == 11'h000;
    endproperty
    a_function_reserved_zero: assert property (p_function_reserved_zero)
        else $error("reserved function bits not zero");

    property p_wait_reserved_ones;
        @(posedge core_clk) disable iff (!rst_n)
        read_wait_state_control[7:2] == 6'h3F && read_wait_state_control[0];
    endproperty
    a_wait_reserved_ones: assert property (p_wait_reserved_ones)
        else $error("reserved wait bits not one");

    property p_manual_reset_keeps;
        @(posedge core_clk) disable iff (!rst_n)
        !manual_rst_n && !psel |=> $stable(bus_area_function_control)
                                   && $stable(read_wait_state_control);
    endproperty
    a_manual_reset_keeps: assert property (p_manual_reset_keeps)
        else $error("manual reset disturbed registers");

    property p_rom_one_state;
        @(posedge core_clk) disable iff (!rst_n)
        s_rom_start |=> cyc_busy ##1 (cyc_done && !cyc_busy);
    endproperty
    a_rom_one_state: assert property (p_rom_one_state)
        else $error("on-chip rom read not one state");

    property p_periph_three_states;
        @(posedge core_clk) disable iff (!rst_n)
        s_periph_start |=> cyc_busy [*3] ##1 (cyc_done && !cyc_busy);
    endproperty
    a_periph_three_states: assert property (p_periph_three_states)
        else $error("peripheral read not three states");

    property p_muxed_plan;
        @(posedge core_clk) disable iff (!rst_n)
        start && !cyc_req.internal && cyc_req.area == AREA_MUXED_IO && area6_muxed_io_enable
        |-> plan.base_states == STATES_MUXED && plan.sample_wait;
    endproperty
    a_muxed_plan: assert property (p_muxed_plan)
        else $error("muxed io read plan wrong");

    property p_refresh_plan;
        @(posedge core_clk) disable iff (!rst_n)
        start && cyc_req.refresh && !cyc_req.internal && area1_dram_enable
        && cyc_req.area == AREA_DRAM_OR_EXT && read_wait_state_control[READ_WAIT_SAMPLE_LSB + 1]
        |-> !plan.sample_wait && plan.fixed_waits == refresh_wait_count;
    endproperty
    a_refresh_plan: assert property (p_refresh_plan)
        else $error("refresh plan samples wait");

    property p_short_write_pitch;
        @(posedge core_clk) disable iff (!rst_n)
        start && cyc_req.write && !cyc_req.internal && !cyc_req.refresh
        && cyc_req.area == AREA_DRAM_OR_EXT && area1_dram_enable
        && !read_wait_state_control[DRAM_WRITE_PITCH_SELECT_BIT]
        |=> cyc_busy ##1 cyc_done;
    endproperty
    a_short_write_pitch: assert property (p_short_write_pitch)
        else $error("short pitch dram write not one state");

    property p_wait_stretches;
        @(posedge core_clk) disable iff (!rst_n)
        final_state && !wait_n && plan_sampled |=> cyc_busy && !cyc_done;
    endproperty
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            plan_sampled <= 1'b0;
        else if (start)
            plan_sampled <= plan.sample_wait;
    end
    a_wait_stretches: assert property (p_wait_stretches)
        else $error("low wait sample did not add a state");

    property p_hold_internal;
        @(posedge core_clk) disable iff (!rst_n)
        cyc_busy && !cyc_req.internal && !parallel_access_mode |-> internal_access_hold;
    endproperty
    a_hold_internal: assert property (p_hold_internal)
        else $error("internal access not held in normal mode");

endmodule

/* File: hdl/bus_area_pkg.sv */
// package: register map, field layout, cycle-length constants and carrier types
package bus_area_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the apb)
    // ------------------------------------------------------------
    localparam logic [7:0]  BUS_AREA_FUNCTION_CONTROL_ADDR = 8'h00;
    localparam logic [7:0]  READ_WAIT_STATE_CONTROL_ADDR   = 8'h04;

    localparam logic [15:0] BUS_AREA_FUNCTION_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] READ_WAIT_STATE_CONTROL_RESET   = 16'hFFFF;

    // writable bits; everything else reads as its fixed value
    localparam logic [15:0] BUS_AREA_WRITABLE_MASK  = 16'hF800;
    localparam logic [15:0] READ_WAIT_WRITABLE_MASK = 16'hFF02;
    localparam logic [15:0] READ_WAIT_FIXED_ONES    = 16'h00FD;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int AREA1_DRAM_ENABLE_BIT        = 15;
    localparam int AREA6_MUXED_IO_ENABLE_BIT    = 14;
    localparam int PARALLEL_ACCESS_MODE_BIT     = 13;
    localparam int READ_STROBE_DUTY_SELECT_BIT  = 12;
    localparam int BYTE_STROBE_STYLE_SELECT_BIT = 11;
    localparam int READ_WAIT_SAMPLE_LSB         = 8;
    localparam int DRAM_WRITE_PITCH_SELECT_BIT  = 1;

    // ------------------------------------------------------------
    // areas and cycle lengths in bus states (one state = one clock)
    // ------------------------------------------------------------
    localparam logic [2:0] AREA_ROM_OR_EXT0 = 3'h0;
    localparam logic [2:0] AREA_DRAM_OR_EXT = 3'h1;
    localparam logic [2:0] AREA_EXT2        = 3'h2;
    localparam logic [2:0] AREA_PERIPH      = 3'h5;
    localparam logic [2:0] AREA_MUXED_IO    = 3'h6;
    localparam logic [2:0] AREA_RAM_OR_EXT7 = 3'h7;

    localparam logic [2:0] STATES_SHORT  = 3'h1;
    localparam logic [2:0] STATES_LONG   = 3'h2;
    localparam logic [2:0] STATES_PERIPH = 3'h3;
    localparam logic [2:0] STATES_MUXED  = 3'h4;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] area;
        logic       internal;
        logic       write;
        logic       refresh;
    } cycle_req_t;

    typedef struct packed {
        logic [2:0] base_states;
        logic [1:0] fixed_waits;
        logic       sample_wait;
    } cycle_plan_t;

endpackage

/* File: hdl/cycle_state_timer.sv */
// module: counts the states of one bus cycle and stretches it while wait is low
`timescale 1ns/1ps

module cycle_state_timer
    import bus_area_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      start,
    input  wire bus_area_pkg::cycle_plan_t plan,
    input  wire logic                      wait_n,
    output logic                           busy,
    output logic                           final_state,
    output logic                           done
);

    typedef enum logic {IDLE, RUN} timer_state_t;

    timer_state_t state;
    logic [2:0]   remaining;
    logic         sample_wait;

    assign busy        = (state == RUN);
    assign final_state = busy && (remaining == 3'h0);

    // ------------------------------------------------------------
    // state sequencing
    // ------------------------------------------------------------
    // wait is only looked at in the last planned state, so a low sample adds
    // exactly one state and is re-sampled in the state it added
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state       <= IDLE;
            remaining   <= 3'h0;
            sample_wait <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                begin
                    if (start)
                    begin
                        state       <= RUN;
                        remaining   <= 3'(plan.base_states + 3'(plan.fixed_waits) - 3'h1);
                        sample_wait <= plan.sample_wait;
                    end
                end
                RUN:
                begin
                    if (remaining != 3'h0)
                        remaining <= 3'(remaining - 3'h1);
                    else if (!(sample_wait && !wait_n))
                        state <= IDLE;
                end
                default:
                    state <= IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            done <= 1'b0;
        else
            done <= final_state && !(sample_wait && !wait_n);
    end

endmodule

/* File: test/wait_model.sv */
// partner model: external device that stretches bus cycles through the wait line
`timescale 1ns/1ps

module wait_model
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       cyc_busy,
    input  wire logic [2:0] hold_states,
    output logic            wait_n
);
    logic [2:0] left;

    // wait line has a pull-up, so it reads high outside a cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            left <= 3'h0;
        else if (!cyc_busy)
            left <= hold_states;
        else if (left != 3'h0)
            left <= left - 3'h1;
    end

    assign wait_n = (left == 3'h0) || !cyc_busy;
endmodule

/* File: test/bus_area_config_read_waits_tb.sv */
// testbench: register access, reset keeping and bus cycle lengths per area
`timescale 1ns/1ps

module bus_area_config_read_waits_tb;
    import bus_area_pkg::*;
    logic        core_clk, rst_n, manual_rst_n, psel, penable, pwrite, pready, pslverr;
    logic        cyc_valid, cyc_ready, cyc_done, cyc_busy, wait_n, internal_access_hold;
    logic        area1_dram_enable, area6_muxed_io_enable, parallel_access_mode, err;
    logic        read_strobe_duty_select, upper_byte_store_strobe_n, lower_byte_store_strobe_n;
    logic        low_byte_select_n, high_byte_select_n, shared_store_strobe_n;
    logic [1:0]  hi_byte_en, long_wait_area02, long_wait_area6, refresh_wait_count;
    logic [7:0]  paddr, lw;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  hold_states;
    logic [15:0] f, w;
    cycle_req_t  cyc_req, r;
    int          n_mismatch, n_tests, h;
    integer      seed;

    bus_area_config_read_waits i_bus_area_config_read_waits (.core_clk, .rst_n,
        .manual_rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cyc_valid, .cyc_req, .hi_byte_en, .cyc_ready, .cyc_done, .cyc_busy,
        .long_wait_area02, .long_wait_area6, .refresh_wait_count, .wait_n,
        .internal_access_hold, .area1_dram_enable, .area6_muxed_io_enable,
        .parallel_access_mode, .read_strobe_duty_select, .upper_byte_store_strobe_n,
        .lower_byte_store_strobe_n, .low_byte_select_n, .high_byte_select_n,
        .shared_store_strobe_n);
    wait_model i_wait_model (.core_clk, .rst_n, .cyc_busy, .hold_states, .wait_n);

    // ------------------------------------------------------------
    // tasks and expectations
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task finish_test;
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // cycle length in states; wait low for hh states from the start of the cycle
    function automatic int exp_len(input cycle_req_t rq, input int hh);
        int b, x;
        logic s;
        b = 1;
        x = 0;
        s = w[8 + rq.area];
        if (rq.internal)
        begin
            b = (rq.area == 3'h5) ? 3 : 1;
            s = 1'b0;
        end
        else if (rq.area == 3'h1 && f[15])
        begin
            if (rq.write)
                s = w[1];
            b = s ? 2 : 1;
            if (rq.refresh)
            begin
                x = s ? int'(lw[1:0]) : 0;
                s = 1'b0;
            end
        end
        else if (rq.area == 3'h6 && f[14])
        begin
            b = 4;
            s = 1'b1;
        end
        else if (rq.area == 3'h1 && rq.write)
        begin
            b = 2;
            s = 1'b1;
        end
        else if (rq.area inside {3'h0, 3'h2, 3'h6})
            x = (rq.area == 3'h6) ? int'(lw[3:2]) : int'(lw[5:4]);
        else
            b = s ? 2 : 1;
        return b + x + ((s && hh >= b + x) ? hh - b - x + 1 : 0);
    endfunction

    task automatic run_cycle(input cycle_req_t rq, input int e);
        int n, k;
        logic up, sh, first;
        logic [2:0] bs;
        n = 0;
        k = 0;
        up = 1'b0;
        sh = 1'b0;
        first = 1'b1;
        bs = 3'h0;
        cyc_valid <= 1'b1;
        cyc_req <= rq;
        @(posedge core_clk);
        while (cyc_ready !== 1'b1 && k < 20)
        begin
            @(posedge core_clk);
            k++;
        end
        cyc_valid <= 1'b0;
        while (cyc_done !== 1'b1 && k < 60)
        begin
            @(posedge core_clk);
            k++;
            if (first && cyc_busy === 1'b1)
                check(32'(internal_access_hold), 32'(!rq.internal && !f[13]));
            first = first && (cyc_busy !== 1'b1);
            n = n + (cyc_busy === 1'b1);
            up = up | (upper_byte_store_strobe_n === 1'b0);
            sh = sh | (shared_store_strobe_n === 1'b0);
            bs = bs | ~{lower_byte_store_strobe_n, low_byte_select_n, high_byte_select_n};
        end
        check(32'(n), 32'(e));
        check(32'(up), 32'(rq.write && !rq.internal && !f[11] && lw[7]));
        check(32'(sh), 32'(rq.write && !rq.internal && f[11]));
        check(32'(bs), 32'({!f[11] && lw[6], f[11] && lw[6], f[11] && lw[7]}
                           & {3{rq.write && !rq.internal}}));
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    initial
    begin
        #400000;
        n_mismatch++;
        finish_test;
    end

    initial
    begin
        {seed, n_mismatch, n_tests} = {32'd82, 64'd0};
        {rst_n, psel, penable, pwrite, paddr, pwdata, cyc_valid, cyc_req} = '0;
        {manual_rst_n, lw, hold_states, f, w} = {1'b1, 43'h0};
        {hi_byte_en, long_wait_area02, long_wait_area6, refresh_wait_count} = 8'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 90; i++)
        begin
            if (i == 30)
            begin
                rst_n <= 1'b0;
                repeat (2) @(posedge core_clk);
                rst_n <= 1'b1;
            end
            if (i == 0 || i == 30)
            begin
                apb(1'b1, 8'h08, 32'hFFFFFFFF);
                check(32'(err), 32'h1);
                apb(1'b0, READ_WAIT_STATE_CONTROL_ADDR, 32'h0);
                check(q, 32'h0000FFFF);
                apb(1'b0, BUS_AREA_FUNCTION_CONTROL_ADDR, 32'h0);
                check(q, 32'h00000000);
            end
            if (i == 60)
            begin
                manual_rst_n <= 1'b0;
                repeat (2) @(posedge core_clk);
                check(32'(cyc_ready), 32'h0);
                manual_rst_n <= 1'b1;
                apb(1'b0, READ_WAIT_STATE_CONTROL_ADDR, 32'h0);
                check(q, {16'h0, w});
            end
            f = 16'($random(seed)) & BUS_AREA_WRITABLE_MASK;
            w = 16'($random(seed)) | READ_WAIT_FIXED_ONES;
            w[1] = w[1] | !f[15];
            apb(1'b1, BUS_AREA_FUNCTION_CONTROL_ADDR, {16'h0, f});
            apb(1'b1, READ_WAIT_STATE_CONTROL_ADDR, {16'h0, w});
            apb(1'b0, READ_WAIT_STATE_CONTROL_ADDR, 32'h0);
            check(q, {16'h0, w});
            apb(1'b0, BUS_AREA_FUNCTION_CONTROL_ADDR, 32'h0);
            check(q, {16'h0, f});
            check({area1_dram_enable, area6_muxed_io_enable, parallel_access_mode,
                   read_strobe_duty_select}, f[15:12]);
            r = 6'($random(seed));
            r.internal = r.internal && (r.area inside {3'h0, 3'h5, 3'h7});
            r.refresh = r.refresh && r.area == 3'h1 && f[15] && !r.write;
            h = $random(seed) & 5;
            lw = 8'($random(seed));
            hold_states <= 3'(h);
            {hi_byte_en, long_wait_area02, long_wait_area6, refresh_wait_count} <= lw;
            run_cycle(r, exp_len(r, h));
        end
        finish_test;
    end
endmodule
